// >>> ldo_analog_model.sv
`timescale 1ns/1ns
`default_nettype none

module ldo_analog_model (
  // Regulator enables from the bank
  input  wire logic [2:0] on,
  // Forced undervoltage per regulator
  input  wire logic [2:0] fault,
  // Comparator outputs
  output var  logic [2:0] power_good
);
  always_comb begin
    power_good = on & ~fault;
  end
endmodule : ldo_analog_model

`default_nettype wire

// >>> ldo_bank_pkg.sv
package ldo_bank_pkg;

  // Register offsets
  localparam logic [7:0] LDO_A_CONTROL_ADDR   = 8'h40;
  localparam logic [7:0] LDO_B_CONTROL_ADDR   = 8'h41;
  localparam logic [7:0] LDO_C_CONTROL_ADDR   = 8'h42;
  localparam logic [7:0] LDO_CONFIG_BANK_ADDR = 8'h43;

  // Control register fields
  localparam int CODE_LSB = 0;
  localparam int CODE_MSB = 4;
  localparam int ON_BIT   = 5;

  // Discharge and status register fields
  localparam int WE_BIT      = 1;
  localparam int DIS_A_BIT   = 2;
  localparam int PGOOD_A_BIT = 5;

  // Reset values
  localparam logic [4:0] CODE_RESET = 5'h00;
  localparam logic       ON_RESET   = 1'b0;
  localparam logic       DIS_RESET  = 1'b0;
  localparam logic       WE_RESET   = 1'b0;
  localparam logic [7:0] DATA_ZERO  = 8'h00;

  // Voltage table: range bases and steps in millivolts
  localparam logic [11:0] RANGE0_BASE_MV = 12'h578;
  localparam logic [11:0] RANGE1_BASE_MV = 12'h866;
  localparam logic [11:0] RANGE2_BASE_MV = 12'h9F6;
  localparam logic [11:0] RANGE3_BASE_MV = 12'hBB8;
  localparam logic [11:0] COARSE_STEP_MV = 12'h064;
  localparam logic [11:0] FINE_STEP_MV   = 12'h032;

  // Per-regulator control bundle
  typedef struct packed {
    logic [4:0]  code;
    logic        on;
    logic        discharge;
    logic [11:0] target_mv;
  } ldo_drive_t;

  // Register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : ldo_bank_pkg

// >>> ldo_control_registers.sv
// How it works
// - Five-bit voltage code per regulator, 40h-42h
// - Code decodes to range and step voltage
// - Bit 5 enables each regulator independently
// - Discharge enables at 43h bits 2-4
// - Discharge only when enabled and regulator off
// - Power-good flags at 43h bits 5-7
// - Power-good reads live comparator level
// - All fields reachable by serial accesses
// - Reserved bits read-only, read as zero
`timescale 1ns/1ns
`default_nettype none

module ldo_control_registers (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Register access from serial interface logic
  input  wire ldo_bank_pkg::reg_req_t    req,
  output var  logic [7:0]                rdata,
  output var  logic                      rvalid,
  // Power-good comparators
  input  wire logic [2:0]                power_good_in,
  // Analog controls
  output var  ldo_bank_pkg::ldo_drive_t  ldo_a,
  output var  ldo_bank_pkg::ldo_drive_t  ldo_b,
  output var  ldo_bank_pkg::ldo_drive_t  ldo_c
);

  // Highest decoded voltage, used by the range checks
  localparam logic [11:0] TOP_MV = 12'(ldo_bank_pkg::RANGE3_BASE_MV + 12'h007 * ldo_bank_pkg::COARSE_STEP_MV);

  // Voltage code to millivolts
  function automatic logic [11:0] code_to_mv(input logic [4:0] code);
    logic [11:0] step;
    step = {9'h000, code[2:0]};
    case (code[4:3])
      2'b00:   code_to_mv = 12'(ldo_bank_pkg::RANGE0_BASE_MV + step * ldo_bank_pkg::COARSE_STEP_MV);
      2'b01:   code_to_mv = 12'(ldo_bank_pkg::RANGE1_BASE_MV + step * ldo_bank_pkg::FINE_STEP_MV);
      2'b10:   code_to_mv = 12'(ldo_bank_pkg::RANGE2_BASE_MV + step * ldo_bank_pkg::FINE_STEP_MV);
      default: code_to_mv = 12'(ldo_bank_pkg::RANGE3_BASE_MV + step * ldo_bank_pkg::COARSE_STEP_MV);
    endcase
  endfunction : code_to_mv

  // Stored fields
  logic [4:0] code_reg [3];
  logic [4:0] code_next [3];
  logic [2:0] on_reg;
  logic [2:0] on_next;
  logic [2:0] dis_reg;
  logic [2:0] dis_next;
  logic       we_reg;
  logic       we_next;
  logic [2:0] pgood_reg;
  logic [2:0] pgood_next;
  logic [7:0] rdata_next;
  logic       rvalid_next;
  ldo_bank_pkg::ldo_drive_t drive_next [3];
  ldo_bank_pkg::ldo_drive_t drive_reg [3];

  // Next-state of writable fields
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      code_next[i] = code_reg[i];
    end
    on_next  = on_reg;
    dis_next = dis_reg;
    we_next  = we_reg;
    if (req.wr) begin
      for (int i = 0; i < 3; i++) begin
        if (req.addr == ldo_bank_pkg::LDO_A_CONTROL_ADDR + 8'(i)) begin
          code_next[i] = req.wdata[ldo_bank_pkg::CODE_MSB:ldo_bank_pkg::CODE_LSB];
          on_next[i]   = req.wdata[ldo_bank_pkg::ON_BIT];
        end
      end
      if (req.addr == ldo_bank_pkg::LDO_CONFIG_BANK_ADDR) begin
        dis_next = req.wdata[ldo_bank_pkg::DIS_A_BIT +: 3];
        we_next  = req.wdata[ldo_bank_pkg::WE_BIT];
        // status and reserved bits not stored
      end
    end
  end

  // Read mux and analog drive
  always_comb begin
    rdata_next  = ldo_bank_pkg::DATA_ZERO;
    rvalid_next = req.rd;
    pgood_next  = power_good_in;
    for (int i = 0; i < 3; i++) begin
      if (req.addr == ldo_bank_pkg::LDO_A_CONTROL_ADDR + 8'(i)) begin
        rdata_next[ldo_bank_pkg::CODE_MSB:ldo_bank_pkg::CODE_LSB] = code_reg[i];
        rdata_next[ldo_bank_pkg::ON_BIT] = on_reg[i];
      end
    end
    if (req.addr == ldo_bank_pkg::LDO_CONFIG_BANK_ADDR) begin
      rdata_next[ldo_bank_pkg::WE_BIT] = we_reg;
      rdata_next[ldo_bank_pkg::DIS_A_BIT +: 3] = dis_reg;
      rdata_next[ldo_bank_pkg::PGOOD_A_BIT +: 3] = pgood_reg;
    end
    if (!req.rd) begin
      rdata_next = ldo_bank_pkg::DATA_ZERO;
    end
    for (int i = 0; i < 3; i++) begin
      drive_next[i].code      = code_reg[i];
      drive_next[i].on        = on_reg[i];
      drive_next[i].discharge = dis_reg[i] & ~on_reg[i];
      drive_next[i].target_mv = code_to_mv(code_reg[i]);
    end
  end

  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        code_reg[i]  <= ldo_bank_pkg::CODE_RESET;
        drive_reg[i] <= '0;
      end
      on_reg    <= {3{ldo_bank_pkg::ON_RESET}};
      dis_reg   <= {3{ldo_bank_pkg::DIS_RESET}};
      we_reg    <= ldo_bank_pkg::WE_RESET;
      pgood_reg <= 3'h0;
      rdata     <= ldo_bank_pkg::DATA_ZERO;
      rvalid    <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        code_reg[i]  <= code_next[i];
        drive_reg[i] <= drive_next[i];
      end
      on_reg    <= on_next;
      dis_reg   <= dis_next;
      we_reg    <= we_next;
      pgood_reg <= pgood_next;
      rdata     <= rdata_next;
      rvalid    <= rvalid_next;
    end
  end

  // Outputs from registered bundles
  assign ldo_a = drive_reg[0];
  assign ldo_b = drive_reg[1];
  assign ldo_c = drive_reg[2];

  // Discharge a only while enabled and off
  discharge_gate_a: assert property (@(posedge clk) disable iff (rst)
    ##1 ldo_a.discharge == ($past(dis_reg[0]) && !$past(on_reg[0])))
    else $error("discharge a path wrong");

  // Discharge b only while enabled and off
  discharge_b_gate_a: assert property (@(posedge clk) disable iff (rst)
    ##1 ldo_b.discharge == ($past(dis_reg[1]) && !$past(on_reg[1])))
    else $error("discharge b path wrong");

  // Discharge c only while enabled and off
  discharge_c_gate_a: assert property (@(posedge clk) disable iff (rst)
    ##1 ldo_c.discharge == ($past(dis_reg[2]) && !$past(on_reg[2])))
    else $error("discharge c path wrong");

  // Enable b write reaches drive in two cycles
  enable_write_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ldo_bank_pkg::LDO_B_CONTROL_ADDR |-> ##2 ldo_b.on == $past(req.wdata[ldo_bank_pkg::ON_BIT], 2))
    else $error("enable b bit not applied");

  // Enable a write reaches drive
  enable_a_write_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ldo_bank_pkg::LDO_A_CONTROL_ADDR |-> ##2 ldo_a.on == $past(req.wdata[ldo_bank_pkg::ON_BIT], 2))
    else $error("enable a bit not applied");

  // Enable c write reaches drive
  enable_c_write_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ldo_bank_pkg::LDO_C_CONTROL_ADDR |-> ##2 ldo_c.on == $past(req.wdata[ldo_bank_pkg::ON_BIT], 2))
    else $error("enable c bit not applied");

  // Write to a leaves other enables
  enable_indep_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ldo_bank_pkg::LDO_A_CONTROL_ADDR |=> on_reg[2:1] == $past(on_reg[2:1]))
    else $error("enable write not independent");

  // Code c write reaches drive
  code_write_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ldo_bank_pkg::LDO_C_CONTROL_ADDR
      |-> ##2 ldo_c.code == $past(req.wdata[ldo_bank_pkg::CODE_MSB:ldo_bank_pkg::CODE_LSB], 2))
    else $error("voltage code c not applied");

  // Code a write reaches drive
  code_a_write_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ldo_bank_pkg::LDO_A_CONTROL_ADDR
      |-> ##2 ldo_a.code == $past(req.wdata[ldo_bank_pkg::CODE_MSB:ldo_bank_pkg::CODE_LSB], 2))
    else $error("voltage code a not applied");

  // Code b write reaches drive
  code_b_write_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ldo_bank_pkg::LDO_B_CONTROL_ADDR
      |-> ##2 ldo_b.code == $past(req.wdata[ldo_bank_pkg::CODE_MSB:ldo_bank_pkg::CODE_LSB], 2))
    else $error("voltage code b not applied");

  // Decoded voltage a in range once out of reset
  decode_range_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> ldo_a.target_mv >= ldo_bank_pkg::RANGE0_BASE_MV && ldo_a.target_mv <= TOP_MV)
    else $error("decoded voltage a out of range");

  // Decoded voltage b in range once out of reset
  decode_b_range_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> ldo_b.target_mv >= ldo_bank_pkg::RANGE0_BASE_MV && ldo_b.target_mv <= TOP_MV)
    else $error("decoded voltage b out of range");

  // Decoded voltage c in range once out of reset
  decode_c_range_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> ldo_c.target_mv >= ldo_bank_pkg::RANGE0_BASE_MV && ldo_c.target_mv <= TOP_MV)
    else $error("decoded voltage c out of range");

  // Top code decodes to top voltage
  decode_top_a: assert property (@(posedge clk) disable iff (rst)
    ##1 $past(code_reg[0]) == 5'h1F |-> ldo_a.target_mv == TOP_MV)
    else $error("top code decode wrong");

  // Second range starts at its base
  decode_base_a: assert property (@(posedge clk) disable iff (rst)
    ##1 $past(code_reg[1]) == 5'h08 |-> ldo_b.target_mv == ldo_bank_pkg::RANGE1_BASE_MV)
    else $error("second range base wrong");

  // Third range starts at its base
  decode_mid_base_a: assert property (@(posedge clk) disable iff (rst)
    ##1 $past(code_reg[1]) == 5'h10 |-> ldo_b.target_mv == ldo_bank_pkg::RANGE2_BASE_MV)
    else $error("third range base wrong");

  // Top range starts at its base
  decode_high_base_a: assert property (@(posedge clk) disable iff (rst)
    ##1 $past(code_reg[1]) == 5'h18 |-> ldo_b.target_mv == ldo_bank_pkg::RANGE3_BASE_MV)
    else $error("top range base wrong");

  // Fine range steps by the fine step
  decode_fine_step_a: assert property (@(posedge clk) disable iff (rst)
    ##1 $past(code_reg[1]) == 5'h09
      |-> ldo_b.target_mv == 12'(ldo_bank_pkg::RANGE1_BASE_MV + ldo_bank_pkg::FINE_STEP_MV))
    else $error("fine step decode wrong");

  // Power-good read is live
  pgood_read_a: assert property (@(posedge clk) disable iff (rst)
    req.rd && req.addr == ldo_bank_pkg::LDO_CONFIG_BANK_ADDR
      |=> rdata[ldo_bank_pkg::PGOOD_A_BIT +: 3] == $past(pgood_reg))
    else $error("power-good read mismatch");

  // Reserved bits read zero
  reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
    rvalid && $past(req.addr) != ldo_bank_pkg::LDO_CONFIG_BANK_ADDR |-> rdata[7:6] == 2'b00)
    else $error("reserved bits nonzero");

  // Write-exact bit read back
  we_readback_a: assert property (@(posedge clk) disable iff (rst)
    req.rd && req.addr == ldo_bank_pkg::LDO_CONFIG_BANK_ADDR |=> rdata[1] == $past(we_reg) && rdata[0] == 1'b0)
    else $error("write-exact readback wrong");

  // Status bits ignore writes
  status_hold_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> pgood_reg == $past(power_good_in))
    else $error("power-good flag not live");

  // Discharge write stored
  dis_write_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ldo_bank_pkg::LDO_CONFIG_BANK_ADDR
      |=> dis_reg == $past(req.wdata[ldo_bank_pkg::DIS_A_BIT +: 3]))
    else $error("discharge bits not stored");

  // Discharge enables read back
  dis_read_a: assert property (@(posedge clk) disable iff (rst)
    req.rd && req.addr == ldo_bank_pkg::LDO_CONFIG_BANK_ADDR
      |=> rdata[ldo_bank_pkg::DIS_A_BIT +: 3] == $past(dis_reg))
    else $error("discharge readback wrong");

  // Read answered next cycle
  read_answer_a: assert property (@(posedge clk) disable iff (rst)
    req.rd |=> rvalid)
    else $error("read not answered");

  // No answer without a read
  rvalid_pulse_a: assert property (@(posedge clk) disable iff (rst)
    !req.rd |=> !rvalid)
    else $error("answer without read");

  // Read data zero between answers
  read_idle_zero_a: assert property (@(posedge clk) disable iff (rst)
    !rvalid |-> rdata == ldo_bank_pkg::DATA_ZERO)
    else $error("read data not zero when idle");

  // Control register a read back
  ctrl_read_a: assert property (@(posedge clk) disable iff (rst)
    req.rd && req.addr == ldo_bank_pkg::LDO_A_CONTROL_ADDR
      |=> rdata[ldo_bank_pkg::CODE_MSB:ldo_bank_pkg::CODE_LSB] == $past(code_reg[0])
          && rdata[ldo_bank_pkg::ON_BIT] == $past(on_reg[0]))
    else $error("control register readback wrong");

  // Power-good clears below threshold
  pgood_live_a: assert property (@(posedge clk) disable iff (rst)
    ##1 !$past(power_good_in[0]) |-> !pgood_reg[0])
    else $error("power-good set while below threshold");

  // Power-good sets when output good
  pgood_rise_a: assert property (@(posedge clk) disable iff (rst)
    ##1 $past(power_good_in[0]) |-> pgood_reg[0])
    else $error("power-good clear while output good");

  // Unmapped writes above 43h leave enables, discharge and write-exact bit
  unmapped_write_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr > ldo_bank_pkg::LDO_CONFIG_BANK_ADDR
      |=> on_reg == $past(on_reg) && dis_reg == $past(dis_reg) && we_reg == $past(we_reg))
    else $error("unmapped write changed state");

  // Write-exact bit stored on write
  we_store_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ldo_bank_pkg::LDO_CONFIG_BANK_ADDR
      |=> we_reg == $past(req.wdata[ldo_bank_pkg::WE_BIT]))
    else $error("write-exact bit not stored");

endmodule : ldo_control_registers

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic                     clk;
  logic                     rst;
  ldo_bank_pkg::reg_req_t   req;
  logic [7:0]               rdata;
  logic                     rvalid;
  logic [2:0]               power_good_in;
  logic [2:0]               fault;
  ldo_bank_pkg::ldo_drive_t ldo_a;
  ldo_bank_pkg::ldo_drive_t ldo_b;
  ldo_bank_pkg::ldo_drive_t ldo_c;
  int                       err_total = 0;
  int                       checked = 0;
  int                       cyc = 0;

  // Bank under test
  ldo_control_registers i_ldo_control_registers (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .rvalid(rvalid), .power_good_in(power_good_in), .ldo_a(ldo_a), .ldo_b(ldo_b), .ldo_c(ldo_c));
  // Regulator comparators
  ldo_analog_model i_ldo_analog_model (.on({ldo_c.on, ldo_b.on, ldo_a.on}), .fault(fault),
    .power_good(power_good_in));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
    chk("rdata", {8'h00, exp}, {8'h00, rdata});
    @(posedge clk);
    #1;
    chk("rvalid drop", 16'h0000, {15'h0000, rvalid});
  endtask : reg_read

  // Settle one edge after a write so the drive outputs carry it
  task automatic settle;
    @(posedge clk);
    #1;
  endtask : settle

  // Expected millivolts of a voltage code
  function automatic logic [15:0] volt(input logic [4:0] c);
    case (c[4:3])
      2'h0: volt = 16'h0578 + 16'h0064 * c[2:0];
      2'h1: volt = 16'h0866 + 16'h0032 * c[2:0];
      2'h2: volt = 16'h09F6 + 16'h0032 * c[2:0];
      default: volt = 16'h0BB8 + 16'h0064 * c[2:0];
    endcase
  endfunction : volt

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end

  // Test sequence
  initial begin
    rst = 1'b1;
    req = '0;
    fault = 3'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    reg_read(8'h40, 8'h00);
    reg_read(8'h43, 8'h00);
    reg_read(8'h44, 8'h00);
    $display("test reset done");
    reg_write(8'h40, 8'hFF);
    settle();
    chk("a on", 16'h0001, {15'h0000, ldo_a.on});
    chk("a code", 16'h001F, {11'h000, ldo_a.code});
    chk("a mv", 16'h0E74, {4'h0, ldo_a.target_mv});
    reg_read(8'h40, 8'h3F);
    reg_write(8'h42, 8'h20);
    settle();
    chk("c on", 16'h0001, {15'h0000, ldo_c.on});
    chk("c code", 16'h0000, {11'h000, ldo_c.code});
    chk("c mv", 16'h0578, {4'h0, ldo_c.target_mv});
    for (int i = 0; i < 32; i++) begin
      reg_write(8'h41, {3'h0, i[4:0]});
      settle();
      chk("b code", {11'h000, i[4:0]}, {11'h000, ldo_b.code});
      chk("b mv", volt(i[4:0]), {4'h0, ldo_b.target_mv});
      chk("b on", 16'h0000, {15'h0000, ldo_b.on});
      chk("a on kept", 16'h0001, {15'h0000, ldo_a.on});
    end
    reg_read(8'h41, 8'h1F);
    reg_read(8'h42, 8'h20);
    $display("test control done");
    reg_write(8'h43, 8'hFD);
    settle();
    chk("discharge", 16'h0002, {13'h0000, ldo_c.discharge, ldo_b.discharge, ldo_a.discharge});
    reg_read(8'h43, 8'hBC);
    @(posedge clk);
    fault <= 3'h1;
    repeat (2) @(posedge clk);
    reg_read(8'h43, 8'h9C);
    reg_write(8'h40, 8'h00);
    settle();
    chk("a discharge", 16'h0001, {15'h0000, ldo_a.discharge});
    reg_write(8'h43, 8'hE1);
    settle();
    chk("discharge off", 16'h0000, {13'h0000, ldo_c.discharge, ldo_b.discharge, ldo_a.discharge});
    reg_read(8'h43, 8'h80);
    reg_write(8'h44, 8'hFF);
    reg_read(8'h40, 8'h00);
    reg_read(8'h42, 8'h20);
    $display("test status done");
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire
